/* src/bpdc_defines.svh */
// bpdc_defines.svh: figures shared by the burst page dram sequencer
// assumes: included by bare name, once per file that needs them
//
// Function
// - Simple read data after 4 or 5 clocks
// - Two idle row strobe clocks between cycles
// - Every access starts simple, promoted by inputs
// - Outputs registered except row address path
// - Burst runs until cancel, suspend or end
// - Only refresh overdue past 80% preempts burst
// - First cycle: row strobe on initial bank
// - Second cycle: first column, other row strobe
// - First burst word ready in fourth cycle
// - Fast start bit clear adds one cycle
// - Instruction group: own inputs, acks, buffers
// - Data group: own inputs, acks, buffer enables
// - Instruction and data accesses never overlap
// - Bank indicator high when bank B next
// - Refresh every 16 times field plus one
`ifndef BPDC_DEFINES_SVH
`define BPDC_DEFINES_SVH

// word address bit that picks the interleaved bank
`define BPDC_BANK_BIT 2
// refresh divider field width and prescale
`define BPDC_DIV_W 6
`define BPDC_REF_PRESCALE 16
// overdue threshold as a fraction: 80 percent
`define BPDC_OVD_NUM 4
`define BPDC_OVD_DEN 5
// row strobe clocks of one refresh cycle
`define BPDC_REF_RAS_CYC 2'h3
// request type codes accepted as memory space
`define BPDC_ITYPE_MEM 1'h0
`define BPDC_DTYPE_IO_BIT 1
// option code of a full word access
`define BPDC_OPT_WORD 3'h0

`endif

/* src/bpdc_pkg.sv */
// bpdc_pkg: types of the burst page dram sequencer
// assumes: compiled before every other design file
package bpdc_pkg;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ROW,
      ST_COL,
      ST_LAT,
      ST_XTRA,
      ST_DATA,
      ST_BURST,
      ST_SUSP,
      ST_TERM,
      ST_PRE,
      ST_REF
   } bpdc_state_t;

endpackage

/* src/bpdc_req_if.sv */
// bpdc_req_if: arbitrated request between arbiter and sequencer
// assumes: arbiter drives, sequencer answers with take
interface bpdc_req_if;

   logic valid;
   logic pick_pipe;
   logic pick_read;
   logic pick_partial;
   logic own_data;
   logic own_req;
   logic own_burst;
   logic take;

   modport arb (
      output valid,
      output pick_pipe,
      output pick_read,
      output pick_partial,
      output own_data,
      output own_req,
      output own_burst,
      input  take
   );

   modport seq (
      input  valid,
      input  pick_pipe,
      input  pick_read,
      input  pick_partial,
      input  own_data,
      input  own_req,
      input  own_burst,
      output take
   );

endinterface

/* src/bpdc_arbiter.sv */
// bpdc_arbiter: picks instruction or data request for one memory block
// assumes: inputs synchronous to clk_i; owner held from take to next take
`include "bpdc_defines.svh"

module bpdc_arbiter (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   // common
   input  wire logic       mem_select_i,
   input  wire logic       data_read_i,
   // instruction group
   input  wire logic       instr_request_i,
   input  wire logic       instr_burst_request_i,
   input  wire logic       instr_request_type_i,
   input  wire logic       instr_pipeline_flag_i,
   // data group
   input  wire logic       data_request_i,
   input  wire logic       data_burst_request_i,
   input  wire logic [1:0] data_request_type_i,
   input  wire logic [2:0] data_option_code_i,
   input  wire logic       data_pipeline_flag_i,
   // to sequencer
   bpdc_req_if.arb         rq
);

   logic i_ok;
   logic d_ok;
   logic pick_d;
   logic own_d_r;

   assign i_ok = instr_request_i & mem_select_i
               & (instr_request_type_i == `BPDC_ITYPE_MEM);
   assign d_ok = data_request_i & mem_select_i
               & ~data_request_type_i[`BPDC_DTYPE_IO_BIT];
   // alternate when both wait, so neither side starves
   assign pick_d = d_ok & (~i_ok | ~own_d_r);

   assign rq.valid        = i_ok | d_ok;
   assign rq.pick_pipe    = pick_d ? data_pipeline_flag_i
                                   : instr_pipeline_flag_i;
   assign rq.pick_read    = pick_d ? data_read_i : 1'b1;
   assign rq.pick_partial = pick_d & (data_option_code_i != `BPDC_OPT_WORD);
   assign rq.own_data     = own_d_r;
   assign rq.own_req      = own_d_r ? data_request_i : instr_request_i;
   assign rq.own_burst    = own_d_r ? data_burst_request_i
                                    : instr_burst_request_i;

   // one owner at a time; the other group waits for the next take
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         own_d_r <= 1'b0;
      else if (rq.take)
         own_d_r <= pick_d;
   end

endmodule

/* src/bpdc_refresh.sv */
// bpdc_refresh: refresh request timer, overdue detector, row counter
// assumes: ack_i pulses one cycle when a refresh cycle starts
`include "bpdc_defines.svh"

module bpdc_refresh #(
   parameter int ROW_W = 11,
   parameter int DIV_W = `BPDC_DIV_W
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // control
   input  wire logic [DIV_W-1:0] div_i,
   input  wire logic             ack_i,
   // status
   output logic                  pending_o,
   output logic                  overdue_o,
   output logic [ROW_W-1:0]      row_o
);

   localparam int PER_W = DIV_W + 5;
   localparam int OV_W  = PER_W + 3;

   logic [PER_W-1:0] period;
   logic [PER_W-1:0] tick_cnt_r;
   logic [PER_W-1:0] age_r;
   logic             tick;
   logic             pending_r;
   logic [ROW_W-1:0] row_r;

   assign period = PER_W'(div_i) * PER_W'(`BPDC_REF_PRESCALE)
                 + PER_W'(`BPDC_REF_PRESCALE);
   // >= so that a smaller field takes effect at once
   assign tick = (tick_cnt_r >= period - PER_W'(1));

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         tick_cnt_r <= '0;
      else if (tick)
         tick_cnt_r <= '0;
      else
         tick_cnt_r <= tick_cnt_r + PER_W'(1);
   end

   // a new tick beats the acknowledge of the old one
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         pending_r <= 1'b0;
      else
         pending_r <= tick | (pending_r & ~ack_i);
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         age_r <= '0;
      else if (ack_i || !pending_r)
         age_r <= '0;
      else if (age_r != {PER_W{1'b1}})
         age_r <= age_r + PER_W'(1);
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         row_r <= '0;
      else if (ack_i)
         row_r <= row_r + ROW_W'(1);
   end

   assign pending_o = pending_r;
   assign overdue_o = pending_r
      & (OV_W'(age_r) * OV_W'(`BPDC_OVD_DEN)
         > OV_W'(period) * OV_W'(`BPDC_OVD_NUM));
   assign row_o     = row_r;

endmodule

/* src/bpdc_top.sv */
// bpdc_top: access sequencer for two interleaved page mode dram banks
// assumes: processor inputs synchronous to clk_i; strobes active high,
// pads invert them; configuration fields held steady by the system
`include "bpdc_defines.svh"

module bpdc_top #(
   parameter int ADDR_W = 11
) (
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   reset_n_i,
   // configuration fields
   input  wire logic                   cfg_fast_start_i,
   input  wire logic [`BPDC_DIV_W-1:0] cfg_refresh_div_i,
   // processor address and common controls
   input  wire logic [2*ADDR_W+2:0]    proc_addr_i,
   input  wire logic                   mem_select_i,
   input  wire logic                   data_read_i,
   // instruction group
   input  wire logic                   instr_request_i,
   input  wire logic                   instr_burst_request_i,
   input  wire logic                   instr_request_type_i,
   input  wire logic                   instr_pipeline_flag_i,
   // data group
   input  wire logic                   data_request_i,
   input  wire logic                   data_burst_request_i,
   input  wire logic [1:0]             data_request_type_i,
   input  wire logic [2:0]             data_option_code_i,
   input  wire logic                   data_pipeline_flag_i,
   // dram side
   output logic [ADDR_W-1:0]           dram_addr_o,
   output logic                        row_strobe_bank_a_o,
   output logic                        row_strobe_bank_b_o,
   output logic                        col_strobe_bank_a_o,
   output logic                        col_strobe_bank_b_o,
   output logic                        dram_write_o,
   // instruction answers
   output logic                        instr_burst_ack_o,
   output logic                        instr_ready_o,
   // data answers
   output logic                        data_burst_ack_o,
   output logic                        data_ready_o,
   // buffer controls
   output logic                        instr_buf_transmit_a_o,
   output logic                        instr_buf_transmit_b_o,
   output logic                        data_buf_transmit_a_o,
   output logic                        data_buf_transmit_b_o,
   output logic                        data_buf_chip_enable_a_o,
   output logic                        data_buf_chip_enable_b_o,
   output logic                        next_bank_indicator_o
);

   typedef bpdc_pkg::bpdc_state_t bpdc_st_t;

   function automatic logic is_rdy(input bpdc_st_t st);
      is_rdy = (st == bpdc_pkg::ST_DATA) || (st == bpdc_pkg::ST_BURST);
   endfunction

   function automatic logic in_start(input bpdc_st_t st);
      in_start = (st == bpdc_pkg::ST_ROW) || (st == bpdc_pkg::ST_COL)
              || (st == bpdc_pkg::ST_LAT) || (st == bpdc_pkg::ST_XTRA);
   endfunction

   function automatic logic in_col(input bpdc_st_t st);
      in_col = (in_start(st) && st != bpdc_pkg::ST_ROW) || is_rdy(st)
            || (st == bpdc_pkg::ST_SUSP);
   endfunction

   bpdc_req_if rq ();

   logic              ref_pending;
   logic              ref_overdue;
   logic              ref_go;
   logic [ADDR_W-1:0] ref_row;

   bpdc_st_t          state_r;
   bpdc_st_t          state_nxt;
   logic              bank_r;
   logic              bank_nxt;
   logic [ADDR_W-1:0] col_r;
   logic [ADDR_W-1:0] col_nxt;
   logic              read_r;
   logic              read_nxt;
   logic              partial_r;
   logic              burst_r;
   logic              burst_set;
   logic              burst_any;
   logic              pend_r;
   logic              pend_set;
   logic [1:0]        ref_cnt_r;
   logic              page_end;
   logic              step;
   logic              rdy_nxt;
   logic              ras_a_nxt;
   logic              ras_b_nxt;
   logic              cas_a_nxt;
   logic              cas_b_nxt;
   logic              col_phase_r;
   logic              ref_phase_r;

   bpdc_arbiter u_arb (
      .clk_i                 (clk_i),
      .reset_n_i             (reset_n_i),
      .mem_select_i          (mem_select_i),
      .data_read_i           (data_read_i),
      .instr_request_i       (instr_request_i),
      .instr_burst_request_i (instr_burst_request_i),
      .instr_request_type_i  (instr_request_type_i),
      .instr_pipeline_flag_i (instr_pipeline_flag_i),
      .data_request_i        (data_request_i),
      .data_burst_request_i  (data_burst_request_i),
      .data_request_type_i   (data_request_type_i),
      .data_option_code_i    (data_option_code_i),
      .data_pipeline_flag_i  (data_pipeline_flag_i),
      .rq                    (rq.arb)
   );

   bpdc_refresh #(
      .ROW_W (ADDR_W)
   ) u_ref (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .div_i     (cfg_refresh_div_i),
      .ack_i     (ref_go),
      .pending_o (ref_pending),
      .overdue_o (ref_overdue),
      .row_o     (ref_row)
   );

   // last word of the page sits in bank b at the top column
   assign page_end  = bank_r & (col_r == {ADDR_W{1'b1}});
   // promotion only while the owner drives both request lines
   assign burst_set = in_start(state_r) & rq.own_req & rq.own_burst
                    & ~partial_r;
   assign burst_any = burst_r | burst_set;

   always_comb
   begin
      state_nxt = state_r;
      rq.take   = 1'b0;
      pend_set  = 1'b0;
      ref_go    = 1'b0;
      case (state_r)
         bpdc_pkg::ST_IDLE, bpdc_pkg::ST_PRE:
         begin
            if (pend_r)
               state_nxt = bpdc_pkg::ST_ROW;
            else if (ref_pending)
            begin
               ref_go    = 1'b1;
               state_nxt = bpdc_pkg::ST_REF;
            end
            else if (rq.valid)
            begin
               rq.take   = 1'b1;
               state_nxt = bpdc_pkg::ST_ROW;
            end
            else
               state_nxt = bpdc_pkg::ST_IDLE;
         end
         bpdc_pkg::ST_ROW:
            state_nxt = bpdc_pkg::ST_COL;
         bpdc_pkg::ST_COL:
            state_nxt = bpdc_pkg::ST_LAT;
         bpdc_pkg::ST_LAT:
            state_nxt = cfg_fast_start_i ? bpdc_pkg::ST_DATA
                                         : bpdc_pkg::ST_XTRA;
         bpdc_pkg::ST_XTRA:
            state_nxt = bpdc_pkg::ST_DATA;
         bpdc_pkg::ST_DATA:
         begin
            if (burst_any && rq.own_req && rq.own_burst && !page_end
                && !ref_overdue)
               state_nxt = bpdc_pkg::ST_BURST;
            else if (burst_any)
               state_nxt = bpdc_pkg::ST_TERM;
            else
            begin
               // a pipelined request is latched now, run after precharge
               if (rq.valid && rq.pick_pipe)
               begin
                  rq.take  = 1'b1;
                  pend_set = 1'b1;
               end
               state_nxt = bpdc_pkg::ST_PRE;
            end
         end
         bpdc_pkg::ST_BURST:
         begin
            if (!rq.own_req || page_end || ref_overdue)
               state_nxt = bpdc_pkg::ST_TERM;
            else if (!rq.own_burst)
               state_nxt = bpdc_pkg::ST_SUSP;
            else
               state_nxt = bpdc_pkg::ST_BURST;
         end
         bpdc_pkg::ST_SUSP:
         begin
            if (!rq.own_req || page_end || ref_overdue)
               state_nxt = bpdc_pkg::ST_TERM;
            else if (rq.own_burst)
               state_nxt = bpdc_pkg::ST_BURST;
            else
               state_nxt = bpdc_pkg::ST_SUSP;
         end
         bpdc_pkg::ST_REF:
            if (ref_cnt_r == `BPDC_REF_RAS_CYC - 2'h1)
               state_nxt = bpdc_pkg::ST_TERM;
         // both strobes idle here and in precharge: two clocks
         bpdc_pkg::ST_TERM:
            state_nxt = bpdc_pkg::ST_PRE;
         default:
            state_nxt = bpdc_pkg::ST_IDLE;
      endcase
   end

   assign step    = (state_nxt == bpdc_pkg::ST_BURST);
   assign rdy_nxt = is_rdy(state_nxt);

   always_comb
   begin
      bank_nxt = bank_r;
      col_nxt  = col_r;
      read_nxt = rq.take ? rq.pick_read : read_r;
      if (rq.take)
      begin
         bank_nxt = proc_addr_i[`BPDC_BANK_BIT];
         col_nxt  = proc_addr_i[ADDR_W+2:3];
      end
      else if (step)
      begin
         bank_nxt = ~bank_r;
         col_nxt  = bank_r ? col_r + 1'b1 : col_r;
      end
   end

   always_comb
   begin
      ras_a_nxt = 1'b0;
      ras_b_nxt = 1'b0;
      cas_a_nxt = 1'b0;
      cas_b_nxt = 1'b0;
      case (state_nxt)
         bpdc_pkg::ST_ROW:
         begin
            ras_a_nxt = ~bank_nxt;
            ras_b_nxt = bank_nxt;
         end
         bpdc_pkg::ST_COL, bpdc_pkg::ST_LAT, bpdc_pkg::ST_XTRA:
         begin
            ras_a_nxt = 1'b1;
            ras_b_nxt = 1'b1;
            cas_a_nxt = ~bank_nxt;
            cas_b_nxt = bank_nxt;
         end
         bpdc_pkg::ST_DATA, bpdc_pkg::ST_BURST:
         begin
            ras_a_nxt = burst_any;
            ras_b_nxt = burst_any;
            cas_a_nxt = ~bank_nxt;
            cas_b_nxt = bank_nxt;
         end
         bpdc_pkg::ST_SUSP:
         begin
            ras_a_nxt = 1'b1;
            ras_b_nxt = 1'b1;
            cas_a_nxt = col_strobe_bank_a_o;
            cas_b_nxt = col_strobe_bank_b_o;
         end
         bpdc_pkg::ST_REF:
         begin
            ras_a_nxt = 1'b1;
            ras_b_nxt = 1'b1;
         end
         default:
         begin
            ras_a_nxt = 1'b0;
            ras_b_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         state_r <= bpdc_pkg::ST_IDLE;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         bank_r    <= 1'b0;
         col_r     <= '0;
         read_r    <= 1'b1;
         partial_r <= 1'b0;
      end
      else
      begin
         bank_r <= bank_nxt;
         col_r  <= col_nxt;
         read_r <= read_nxt;
         if (rq.take)
            partial_r <= rq.pick_partial;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         burst_r   <= 1'b0;
         pend_r    <= 1'b0;
         ref_cnt_r <= 2'h0;
      end
      else
      begin
         burst_r   <= burst_any & (in_start(state_nxt) | in_col(state_nxt));
         pend_r    <= pend_set | (pend_r & (state_nxt != bpdc_pkg::ST_ROW));
         ref_cnt_r <= (state_r == bpdc_pkg::ST_REF) ? ref_cnt_r + 2'h1
                                                    : 2'h0;
      end
   end

   // strobes and address phase, all from flops
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         row_strobe_bank_a_o <= 1'b0;
         row_strobe_bank_b_o <= 1'b0;
         col_strobe_bank_a_o <= 1'b0;
         col_strobe_bank_b_o <= 1'b0;
         dram_write_o        <= 1'b0;
         col_phase_r         <= 1'b0;
         ref_phase_r         <= 1'b0;
      end
      else
      begin
         row_strobe_bank_a_o <= ras_a_nxt;
         row_strobe_bank_b_o <= ras_b_nxt;
         col_strobe_bank_a_o <= cas_a_nxt;
         col_strobe_bank_b_o <= cas_b_nxt;
         dram_write_o        <= in_col(state_nxt) & ~read_nxt;
         col_phase_r         <= in_col(state_nxt);
         ref_phase_r         <= (state_nxt == bpdc_pkg::ST_REF);
      end
   end

   // row address passes straight from the pins to avoid a clock of lag
   assign dram_addr_o = ref_phase_r ? ref_row
                      : col_phase_r ? col_r
                      : proc_addr_i[2*ADDR_W+2:ADDR_W+3];

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         instr_ready_o     <= 1'b0;
         data_ready_o      <= 1'b0;
         instr_burst_ack_o <= 1'b0;
         data_burst_ack_o  <= 1'b0;
      end
      else
      begin
         instr_ready_o     <= rdy_nxt & ~rq.own_data;
         data_ready_o      <= rdy_nxt & rq.own_data;
         instr_burst_ack_o <= burst_any & in_col(state_nxt) & ~rq.own_data;
         data_burst_ack_o  <= burst_any & in_col(state_nxt) & rq.own_data;
      end
   end

   // buffer enables follow the bank of the word on the bus, except data chip enables in burst writes
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         instr_buf_transmit_a_o   <= 1'b0;
         instr_buf_transmit_b_o   <= 1'b0;
         data_buf_transmit_a_o    <= 1'b0;
         data_buf_transmit_b_o    <= 1'b0;
         data_buf_chip_enable_a_o <= 1'b0;
         data_buf_chip_enable_b_o <= 1'b0;
         next_bank_indicator_o    <= 1'b0;
      end
      else
      begin
         instr_buf_transmit_a_o <= rdy_nxt & ~rq.own_data & ~bank_nxt;
         instr_buf_transmit_b_o <= rdy_nxt & ~rq.own_data & bank_nxt;
         data_buf_transmit_a_o  <= rdy_nxt & rq.own_data & read_nxt
                                 & ~bank_nxt;
         data_buf_transmit_b_o  <= rdy_nxt & rq.own_data & read_nxt
                                 & bank_nxt;
         // burst writes keep both enables on while burst words are ready, both off in suspend
         data_buf_chip_enable_a_o <= rdy_nxt & rq.own_data
                                   & (~bank_nxt | (burst_any & ~read_nxt));
         data_buf_chip_enable_b_o <= rdy_nxt & rq.own_data
                                   & (bank_nxt | (burst_any & ~read_nxt));
         next_bank_indicator_o <= (burst_any & (rdy_nxt
            | (state_nxt == bpdc_pkg::ST_SUSP))) ? ~bank_nxt
                                                 : bank_nxt;
      end
   end

endmodule

/* verif/bpdc_top_props.sv */
// bpdc_top_props: port level timing checks of the dram sequencer
// assumes: bound onto bpdc_top; strobes and readies active high
module bpdc_top_props (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic cfg_fast_start_i,
   // dram strobes
   input wire logic row_strobe_bank_a_o,
   input wire logic row_strobe_bank_b_o,
   input wire logic col_strobe_bank_a_o,
   input wire logic col_strobe_bank_b_o,
   // answers and buffers
   input wire logic instr_ready_o,
   input wire logic data_ready_o,
   input wire logic instr_buf_transmit_a_o,
   input wire logic instr_buf_transmit_b_o,
   input wire logic data_buf_chip_enable_a_o,
   input wire logic data_buf_chip_enable_b_o
);
   timeunit 1ns;
   timeprecision 1ps;
   wire rdy = instr_ready_o | data_ready_o;
   wire col = col_strobe_bank_a_o | col_strobe_bank_b_o;
   wire row = row_strobe_bank_a_o | row_strobe_bank_b_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   chk_col_rows: assert property (($rose(col_strobe_bank_a_o) ||
      $rose(col_strobe_bank_b_o)) |-> row_strobe_bank_a_o &&
      row_strobe_bank_b_o)
      else $error("column strobe without both row strobes");
   chk_row_first: assert property ($rose(col_strobe_bank_a_o) &&
      !$past(col_strobe_bank_b_o) |-> $past(row_strobe_bank_a_o) &&
      !$past(row_strobe_bank_b_o)) else $error("first row strobe bank wrong");
   chk_fast_ready: assert property (cfg_fast_start_i && $rose(col)
      |-> !rdy ##1 !rdy ##1 rdy) else $error("fast access ready misplaced");
   chk_slow_ready: assert property (!cfg_fast_start_i &&
      $rose(col) |-> !rdy [*3] ##1 rdy)
      else $error("slow access ready misplaced");
   chk_row_precharge: assert property ($fell(row) |-> !row [*2])
      else $error("row precharge gap too short");
   chk_no_overlap: assert property (!(instr_ready_o &&
      data_ready_o)) else $error("instruction and data ready together");
   chk_ready_column: assert property (rdy |-> col)
      else $error("ready without column strobe");
   chk_instr_buf: assert property (instr_ready_o |->
      instr_buf_transmit_a_o ^ instr_buf_transmit_b_o)
      else $error("instruction buffer enable wrong");
   chk_data_buf: assert property (data_ready_o |->
      data_buf_chip_enable_a_o || data_buf_chip_enable_b_o)
      else $error("data buffer enable missing");
   cover property (cfg_fast_start_i && $rose(col));
   cover property (!cfg_fast_start_i && $rose(col));
   cover property (rdy ##1 rdy ##1 rdy);
endmodule

bind bpdc_top bpdc_top_props bpdc_top_props_i (
   .clk_i                    (clk_i),
   .reset_n_i                (reset_n_i),
   .cfg_fast_start_i         (cfg_fast_start_i),
   .row_strobe_bank_a_o      (row_strobe_bank_a_o),
   .row_strobe_bank_b_o      (row_strobe_bank_b_o),
   .col_strobe_bank_a_o      (col_strobe_bank_a_o),
   .col_strobe_bank_b_o      (col_strobe_bank_b_o),
   .instr_ready_o            (instr_ready_o),
   .data_ready_o             (data_ready_o),
   .instr_buf_transmit_a_o   (instr_buf_transmit_a_o),
   .instr_buf_transmit_b_o   (instr_buf_transmit_b_o),
   .data_buf_chip_enable_a_o (data_buf_chip_enable_a_o),
   .data_buf_chip_enable_b_o (data_buf_chip_enable_b_o)
);

/* verif/bpdc_proc_model.sv */
// bpdc_proc_model: processor channel side of one request group
// assumes: ready is registered on the rising edge of clk_i
module bpdc_proc_model (
   // channel
   input  wire logic       clk_i,
   input  wire logic       go_i,
   input  wire logic [2:0] words_i,
   input  wire logic       ready_i,
   output logic            req_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] left_r = 3'h0;
   initial req_o = 1'h0;
   // request held up to the edge that samples the last counted ready
   always @(posedge clk_i)
   begin
      if (!req_o && go_i)
      begin
         req_o  <= 1'h1;
         left_r <= words_i;
      end
      else if (req_o && ready_i)
      begin
         left_r <= left_r - 3'h1;
         if (left_r == 3'h1)
            req_o <= 1'h0;
      end
   end
endmodule

/* verif/tb_top.sv */
// tb_top: self checking bench of the burst page dram sequencer
// assumes: bpdc_top and bpdc_top_props compiled alongside
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int AW = 11;
   logic            clk = 1'h0, rst_n = 1'h0, fast = 1'h1, msel = 1'h1;
   logic            drd = 1'h1, bst = 1'h0, pr = 1'h0;
   logic            ra, rb, instr_ready, data_ready, itx_b, dce_b;
   logic [1:0]      go = 2'h0, dtype = 2'h0;
   wire  [1:0]      req;
   logic [2:0]      nwd = 3'h1;
   logic [2*AW+2:0] addr = '0;
   logic [4:0]      q[$];
   int              failures = 0, checks_done = 0, cyc = 0, t0 = -1;

   initial forever #2.5 clk = ~clk;

   bpdc_top #(.ADDR_W(AW)) bpdc_top_i (.clk_i(clk), .reset_n_i(rst_n),
      .cfg_fast_start_i(fast), .cfg_refresh_div_i(6'h01),
      .proc_addr_i(addr), .mem_select_i(msel), .data_read_i(drd),
      .instr_request_i(req[0]), .instr_burst_request_i(req[0] & bst),
      .instr_request_type_i(1'h0), .instr_pipeline_flag_i(1'h0),
      .data_request_i(req[1]), .data_burst_request_i(req[1] & bst),
      .data_request_type_i(dtype), .data_option_code_i(3'h0),
      .data_pipeline_flag_i(1'h0), .dram_addr_o(),
      .row_strobe_bank_a_o(ra), .row_strobe_bank_b_o(rb),
      .col_strobe_bank_a_o(), .col_strobe_bank_b_o(), .dram_write_o(),
      .instr_burst_ack_o(), .instr_ready_o(instr_ready), .data_burst_ack_o(),
      .data_ready_o(data_ready), .instr_buf_transmit_a_o(),
      .instr_buf_transmit_b_o(itx_b), .data_buf_transmit_a_o(),
      .data_buf_transmit_b_o(), .data_buf_chip_enable_a_o(),
      .data_buf_chip_enable_b_o(dce_b), .next_bank_indicator_o());
   bpdc_proc_model instr_proc_i (.clk_i(clk), .go_i(go[0]), .words_i(nwd),
      .ready_i(instr_ready), .req_o(req[0]));
   bpdc_proc_model data_proc_i (.clk_i(clk), .go_i(go[1]), .words_i(nwd),
      .ready_i(data_ready), .req_o(req[1]));

   task check(input logic [4:0] exp, input logic [4:0] got);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED ready word exp %h got %h", exp, got);
      end
   endtask

   task summarize;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // one access; late holds select low for 13 clocks first, so the request waits until then
   task acc(input logic g, input logic bk, input int nw, input logic late);
      int i;
      addr = (2*AW+3)'($urandom);
      addr[2] = bk;
      if (nw > 1)
         addr[AW+2:3] = '0;
      bst = (nw > 1);
      nwd = 3'(nw > 1 ? nw - 1 : 1);
      drd = bst | 1'($urandom);
      dtype = 2'($urandom % 2);
      msel = !late;
      for (i = 0; i < nw; i++)
         q.push_back({g, bk ^ i[0], i == 0 ? (fast ? 3'h3 : 3'h4) : 3'h0});
      go[g] = 1'h1;
      @(negedge clk);
      go[g] = 1'h0;
      if (late)
      begin
         repeat (12) @(negedge clk);
         msel = 1'h1;
      end
      for (i = 0; i < 60 && req[g]; i++)
         @(negedge clk);
   endtask

   // latency counted from the lone row strobe rise to ready
   always @(negedge clk)
   begin
      logic [4:0] seen;
      cyc++;
      if (cyc > 20000)
      begin
         failures++;
         summarize();
      end
      if ((ra ^ rb) && !pr)
         t0 = cyc;
      pr = ra | rb;
      if (instr_ready | data_ready)
      begin
         seen = {data_ready, data_ready ? dce_b : itx_b, t0 < 0 ? 3'h0 : 3'(cyc - t0)};
         t0 = -1;
         if (q.size() == 0)
            check(5'h1F, seen);
         else
            check(q.pop_front(), seen);
      end
   end

   initial
   begin
      int k;
      void'($urandom(99594));
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst_n = 1'h1;
      for (k = 0; k < 14; k++)
      begin
         if (k == 7)
         begin
            repeat (4) @(negedge clk);
            fast = 1'h0;
         end
         acc(1'($urandom), 1'($urandom), k % 3 == 1 ? 4 : 1,
             k % 5 == 3);
      end
      for (k = 0; k < 40 && q.size() > 0; k++)
         @(negedge clk);
      if (q.size() > 0)
         failures++;
      summarize();
   end
endmodule
